//--- frame_seq_pkg.sv
// shared constants and trigger edge detector for the frame sequencer
`timescale 1ns/10ps
package frame_seq_pkg;
    localparam int          TAG_W     = 8;
    localparam logic [7:0]  TAG_RESET = 8'h00;
    localparam logic [7:0]  TAG_STEP  = 8'h01;
    localparam logic        LVL_IDLE  = 1'b0;
    localparam logic        LVL_ACTIVE = 1'b1;
    typedef enum logic {ACQ_IDLE, ACQ_RUN} acq_state_t;
endpackage

module trig_edge (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // raw trigger level and detected rising edge
    input  wire logic trig_level,
    output logic      trig_rise
);
    import frame_seq_pkg::*;

    logic sync_a;
    logic sync_b;
    logic sync_prev;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync_a    <= LVL_IDLE;
            sync_b    <= LVL_IDLE;
            sync_prev <= LVL_IDLE;
        end else begin
            sync_a    <= trig_level; // R11
            sync_b    <= sync_a;
            sync_prev <= sync_b;
        end
    end

    // a held trigger level counts once
    assign trig_rise = sync_b & ~sync_prev; // R11
endmodule // trig_edge

//--- hw_triggered_frame_sequencer.sv
// sequencer for externally triggered capture and host transfer of depth images
// Behaviour
// R1 - with software trigger set, no capture starts without a trigger event
// R2 - with hardware and software trigger set, wait on the external trigger only
// R3 - an external trigger starts acquisition without any host command
// R4 - transfer starts only on a host request; completion marks the image available
// R5 - trigger output stays active throughout acquisition and readout
// R6 - trigger output falls exactly when acquisition and readout finish
// R7 - a trigger starts a new capture only after the previous readout finished
// R8 - external pacer may watch trigger output before issuing another trigger
// R9 - unrequested image is discarded when the next image completes
// R10 - image completing while a transfer runs is discarded
// R11 - trigger input is synchronised and taken once on its rising edge
`timescale 1ns/10ps
module hw_triggered_frame_sequencer #(
    parameter int TAG_WIDTH = frame_seq_pkg::TAG_W
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // mode settings
    input  wire logic                 sw_trigger_en,
    input  wire logic                 hw_trigger_en,
    // external trigger pins
    input  wire logic                 trig_in,
    output logic                      trig_out,
    // sensor control
    output logic                      acq_start,
    input  wire logic                 readout_done,
    // host transfer path
    input  wire logic                 xfer_req,
    output logic                      xfer_start,
    output logic [TAG_WIDTH-1:0]      xfer_tag,
    input  wire logic                 xfer_done,
    output logic                      xfer_busy,
    output logic                      xfer_complete,
    // dropped frame reports
    output logic                      drop_stale,
    output logic                      drop_busy
);
    import frame_seq_pkg::*;

    // capture side
    acq_state_t             acq_state;
    logic                   run_active;
    logic                   trig_rise;
    logic                   modes_armed;
    logic                   take_trig;
    logic                   img_done;
    logic [TAG_WIDTH-1:0]   frame_tag;
    // image slot and transfer side
    logic                   pending;
    logic [TAG_WIDTH-1:0]   pending_tag;
    logic                   req_wait;
    logic                   start_now;
    logic                   slot_load;
    logic                   lose_busy;
    logic                   lose_stale;
    logic [TAG_WIDTH-1:0]   send_tag;

    // the synchroniser costs two cycles of trigger latency
    trig_edge u_trig_edge (
        .core_clk   (core_clk),
        .reset      (reset),
        .trig_level (trig_in),
        .trig_rise  (trig_rise)
    );

    assign run_active = (acq_state == ACQ_RUN);

    // host commands never start a capture; both settings must be on
    assign modes_armed = sw_trigger_en & hw_trigger_en; // R1 R2

    // only an idle sequencer takes an edge, so triggers in a run are lost
    assign take_trig = ~run_active & modes_armed & trig_rise; // R3 R7

    // readout_done outside a capture is meaningless and ignored
    assign img_done = run_active & readout_done;

    // the host request may come before or after the image is ready
    assign start_now = ~xfer_busy & (xfer_req | req_wait) & (pending | img_done); // R4

    // one slot only: a finished image either leaves, waits or is lost
    assign lose_busy  = img_done & xfer_busy; // R10
    assign slot_load  = img_done & ~xfer_busy & ~start_now;
    assign lose_stale = slot_load & pending; // R9

    // the older image always leaves first
    always_comb begin
        send_tag = frame_tag;
        if (pending) begin
            send_tag = pending_tag; // R4
        end
    end

    // capture sequencing
    always_ff @(posedge core_clk) begin
        if (reset) begin
            acq_state <= ACQ_IDLE;
        end else begin
            unique case (acq_state)
                ACQ_IDLE: begin
                    if (take_trig) begin // R3
                        acq_state <= ACQ_RUN;
                    end
                end
                ACQ_RUN: begin
                    // triggers during the run are ignored, not queued
                    if (readout_done) begin // R6 R7
                        acq_state <= ACQ_IDLE;
                    end
                end
            endcase
        end
    end

    // sensor start pulse
    always_ff @(posedge core_clk) begin
        if (reset) begin
            acq_start <= LVL_IDLE;
        end else begin
            acq_start <= take_trig; // R3
        end
    end

    // level follows the state, so the fall lands on the readout end itself
    assign trig_out = run_active; // R5 R6 R8

    // frame numbering
    always_ff @(posedge core_clk) begin
        if (reset) begin
            frame_tag <= TAG_WIDTH'(TAG_RESET);
        end else if (acq_start) begin
            frame_tag <= frame_tag + TAG_WIDTH'(TAG_STEP);
        end
    end

    // single image slot between readout and transfer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pending <= LVL_IDLE;
        end else if (start_now) begin
            // an image arriving with the transfer start takes the freed slot
            pending <= pending & img_done;
        end else if (slot_load) begin
            pending <= LVL_ACTIVE;
        end
    end

    // frame number of the image in the slot
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pending_tag <= TAG_WIDTH'(TAG_RESET);
        end else if (start_now || slot_load) begin
            pending_tag <= frame_tag;
        end
    end

    // unrequested older image overwritten
    always_ff @(posedge core_clk) begin
        if (reset) begin
            drop_stale <= LVL_IDLE;
        end else begin
            drop_stale <= lose_stale; // R9
        end
    end

    // new image lost behind a running transfer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            drop_busy <= LVL_IDLE;
        end else begin
            drop_busy <= lose_busy; // R10
        end
    end

    // host request waiting for an image
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_wait <= LVL_IDLE;
        end else if (start_now) begin
            req_wait <= LVL_IDLE;
        end else if (xfer_req && !xfer_busy) begin
            req_wait <= LVL_ACTIVE; // R4
        end
    end

    // transfer in progress; a stray xfer_done while idle changes nothing
    always_ff @(posedge core_clk) begin
        if (reset) begin
            xfer_busy <= LVL_IDLE;
        end else if (start_now) begin
            xfer_busy <= LVL_ACTIVE; // R4
        end else if (xfer_done) begin
            xfer_busy <= LVL_IDLE;
        end
    end

    // transfer start pulse
    always_ff @(posedge core_clk) begin
        if (reset) begin
            xfer_start <= LVL_IDLE;
        end else begin
            xfer_start <= start_now; // R4
        end
    end

    // request completion pulse
    always_ff @(posedge core_clk) begin
        if (reset) begin
            xfer_complete <= LVL_IDLE;
        end else begin
            xfer_complete <= xfer_busy & xfer_done; // R4
        end
    end

    // frame number of the image on its way to the host
    always_ff @(posedge core_clk) begin
        if (reset) begin
            xfer_tag <= TAG_WIDTH'(TAG_RESET);
        end else if (start_now) begin
            xfer_tag <= send_tag; // R4
        end
    end
endmodule // hw_triggered_frame_sequencer

//--- seq_props.sv
// port assertions for the frame sequencer
`timescale 1ns/10ps
module seq_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // mode settings and trigger pins
    input wire logic sw_trigger_en,
    input wire logic hw_trigger_en,
    input wire logic trig_in,
    input wire logic trig_out,
    // sensor control
    input wire logic acq_start,
    input wire logic readout_done,
    // host transfer path
    input wire logic xfer_start,
    input wire logic xfer_done,
    input wire logic xfer_busy,
    input wire logic xfer_complete,
    // dropped frame reports
    input wire logic drop_busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // sync, edge detect and start register give three cycles of delay
    property p_go; $rose(trig_in) && !trig_out && sw_trigger_en && hw_trigger_en
        |-> ##[2:4] acq_start; endproperty
    a_go: assert property (p_go) else $error("no start");
    property p_up; $rose(trig_out) |-> acq_start; endproperty
    a_up: assert property (p_up) else $error("bad rise");
    property p_one; acq_start |-> !$past(trig_out); endproperty
    a_one: assert property (p_one) else $error("overlap");
    property p_hold; trig_out && !readout_done |=> trig_out; endproperty
    a_hold: assert property (p_hold) else $error("early fall");
    property p_fall; trig_out && readout_done |=> !trig_out; endproperty
    a_fall: assert property (p_fall) else $error("late fall");
    property p_off; (!sw_trigger_en || !hw_trigger_en) [*2] |-> !acq_start; endproperty
    a_off: assert property (p_off) else $error("start off");
    property p_xs; xfer_start |-> xfer_busy && !$past(xfer_busy); endproperty
    a_xs: assert property (p_xs) else $error("bad start");
    property p_cmp; xfer_busy && xfer_done |=> !xfer_busy && xfer_complete; endproperty
    a_cmp: assert property (p_cmp) else $error("no complete");
    property p_drop; trig_out && readout_done && xfer_busy && !xfer_done |=> drop_busy;
    endproperty
    a_drop: assert property (p_drop) else $error("no drop");
    property p_pulse; acq_start |=> !acq_start; endproperty
    a_pulse: assert property (p_pulse) else $error("long start");
    property p_xone; xfer_start |=> !xfer_start; endproperty
    a_xone: assert property (p_xone) else $error("long transfer start");
endmodule // seq_props
bind hw_triggered_frame_sequencer seq_props props_u (.core_clk, .reset, .sw_trigger_en,
    .hw_trigger_en, .trig_in, .trig_out, .acq_start, .readout_done, .xfer_start,
    .xfer_done, .xfer_busy, .xfer_complete, .drop_busy);

//--- seq_partner.sv
// sensor and host transfer path model
`timescale 1ns/10ps
module seq_partner (
    // clock and start pulses from the sequencer
    input  wire logic core_clk,
    input  wire logic acq_start,
    input  wire logic xfer_start,
    // long transfer selection
    input  wire logic slow,
    // completion pulses back to the sequencer
    output logic      readout_done,
    output logic      xfer_done
);
    int rd = 0, xd = 0;
    initial {readout_done, xfer_done} = 2'b00;
    // slow mode keeps the path busy long enough for a second image to finish
    always @(negedge core_clk) begin
        readout_done <= rd == 1;
        xfer_done <= xd == 1;
        rd <= acq_start ? 6 : (rd > 0 ? rd - 1 : 0);
        xd <= xfer_start ? (slow ? 40 : 2) : (xd > 0 ? xd - 1 : 0);
    end
endmodule // seq_partner

//--- tb_top.sv
// self-checking bench for the frame sequencer
`timescale 1ns/10ps
module tb_top;
    import frame_seq_pkg::*;
    logic core_clk = 0, reset = 1, sw_trigger_en = 0, hw_trigger_en = 1, trig_in = 0;
    logic xfer_req = 0, slow = 0, trig_out, acq_start, readout_done, xfer_start, xfer_done;
    logic xfer_busy, xfer_complete, drop_stale, drop_busy;
    logic [TAG_W-1:0] xfer_tag, last_tag = TAG_RESET;
    int error_cnt = 0, comparisons = 0, cyc = 0, n_acq = 0, n_st = 0, n_bz = 0, n_cp = 0;
    hw_triggered_frame_sequencer dut_u (.core_clk, .reset, .sw_trigger_en, .hw_trigger_en,
        .trig_in, .trig_out, .acq_start, .readout_done, .xfer_req, .xfer_start, .xfer_tag,
        .xfer_done, .xfer_busy, .xfer_complete, .drop_stale, .drop_busy);
    seq_partner part_u (.core_clk, .acq_start, .xfer_start, .slow, .readout_done, .xfer_done);
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        n_acq <= n_acq + int'(acq_start === 1'b1);
        n_st <= n_st + int'(drop_stale === 1'b1);
        n_bz <= n_bz + int'(drop_busy === 1'b1);
        n_cp <= n_cp + int'(xfer_complete === 1'b1);
        if (xfer_start === 1'b1) last_tag <= xfer_tag;
        if (cyc == 2000) begin
            error_cnt++;
            end_of_test;
        end
    end
    task chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task trig;
        @(negedge core_clk) trig_in = 1;
        repeat (5) @(negedge core_clk);
        trig_in = 0;
    endtask
    // pacer waits for the trigger output to fall before going on
    task idle;
        for (int i = 0; i < 60 && trig_out !== 1'b0; i++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
    endtask
    // host asks for each image by a separate request
    task req;
        @(negedge core_clk) xfer_req = 1;
        @(negedge core_clk) xfer_req = 0;
        repeat (8) @(negedge core_clk);
    endtask
    task s_modes;
        trig;
        idle;
        sw_trigger_en = 1;
        hw_trigger_en = 0;
        trig;
        idle;
        chk("acq", n_acq, 0);
        hw_trigger_en = 1;
    endtask
    task s_cap;
        trig;
        chk("trig_out", trig_out, 1);
        trig;
        idle;
        chk("acq", n_acq, 1);
        chk("trig_out", trig_out, 0);
        chk("done", n_cp, 0);
        req;
        chk("tag", last_tag, 1);
        chk("done", n_cp, 1);
    endtask
    task s_stale;
        trig;
        idle;
        trig;
        idle;
        chk("stale", n_st, 1);
        req;
        chk("tag", last_tag, 3);
    endtask
    task s_busy;
        slow = 1;
        req;
        chk("acq", n_acq, 3);
        trig;
        idle;
        trig;
        idle;
        chk("busy", n_bz, 1);
        repeat (40) @(negedge core_clk);
        chk("done", n_cp, 3);
    endtask
    // a level held past the end of the capture must not start another one
    task s_level;
        @(negedge core_clk) trig_in = 1;
        repeat (20) @(negedge core_clk);
        chk("trig_out", trig_out, 0);
        trig_in = 0;
        repeat (3) @(negedge core_clk);
        chk("acq", n_acq, 6);
        chk("stale", n_st, 1);
    endtask
    task end_of_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge core_clk);
        reset = 0;
        s_modes;
        s_cap;
        s_stale;
        s_busy;
        s_level;
        end_of_test;
    end
endmodule // tb_top
